//--- hdl/dac_cfg_pkg.sv
package dac_cfg_pkg;

  // ----------------------------------------
  // Register addresses (13-bit to serve the long instruction form)
  // ----------------------------------------
  localparam int ADDR_W = 13;
  localparam logic [12:0] ADDR_SERIAL_CTL = 13'h0000;
  localparam logic [12:0] ADDR_DATA_PATH = 13'h0002;
  localparam logic [12:0] ADDR_REVISION = 13'h000D;
  localparam logic [12:0] ADDR_CAL_STATE = 13'h000E;
  localparam logic [12:0] ADDR_CAL_CMD = 13'h000F;
  localparam logic [12:0] ADDR_COEF_ADDR = 13'h0010;
  localparam logic [12:0] ADDR_COEF_VALUE = 13'h0011;
  localparam logic [12:0] ADDR_TRIM = 13'h0014;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CAL_SRC_LSB = 4;
  localparam int CAL_DONE_BIT = 7;
  localparam int CAL_START_BIT = 6;
  localparam int STORE_BIT = 3;
  localparam int FETCH_BIT = 2;
  localparam int RESTORE_BIT = 0;
  localparam int TRIM_SCALE_BIT = 4;

  // ----------------------------------------
  // Reset values and constants
  // ----------------------------------------
  localparam logic [7:0] SERIAL_CTL_RESET = 8'h80;
  localparam logic [7:0] DATA_PATH_RESET = 8'h00;
  localparam logic [2:0] DIVIDER_RESET = 3'h0;
  localparam logic [5:0] COEF_ADDR_RESET = 6'h00;
  localparam logic [5:0] COEF_VALUE_RESET = 6'h3F;
  localparam logic [5:0] COEF_DEFAULT = 6'h20;
  localparam logic [8:0] DIV_BASE_PERIOD = 9'h100;
  localparam int COEF_DEPTH = 64;
  // Arbitrary revision code
  localparam logic [3:0] REVISION_CODE = 4'h1;

  // Calibration source codes
  localparam logic [1:0] SRC_COEFFICIENT_RESTORE_DEFAULT = 2'h0;
  localparam logic [1:0] SRC_SELF = 2'h1;
  localparam logic [1:0] SRC_USER = 2'h3;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic serial_pin_direction_select;
    logic bit_order_select;
    logic soft_reset_request;
    logic long_instruction_select;
    logic full_power_down;
    logic sleep;
    logic master_clock_gate;
    logic reference_source_select;
  } serial_ctl_t;

  typedef struct packed {
    logic sample_coding_select;
    logic [1:0] unused_hi;
    logic sample_latch_edge_select;
    logic input_retime_stage_enable;
    logic clock_input_type_select;
    logic unused_lo;
    logic calibration_clock_enable;
  } data_cfg_t;

  // One byte access from the serial port controller
  typedef struct packed {
    logic wr;
    logic rd;
    logic [12:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b01,
    CAL_RUN = 2'b10
  } cal_state_t;

endpackage

//--- hdl/dac_serial_config_registers.sv
`timescale 1ns/1ps

// Behaviour
// (R1) Port config applies on byte's last bit
// (R2) Soft reset defaults all but control
// (R3) Soft reset bit self-clears when done
// (R4) Host uses single-byte config/reset writes
// (R5) Pin direction: 0 four-wire, 1 three-wire
// (R6) Bit order: 0 MSB first, 1 LSB
// (R7) Long instruction: 5 or 13 address bits
// (R8) Power-down stops all but serial port
// (R9) Sleep turns converter output current off
// (R10) Clock gate disables internal master clock
// (R11) Reference select: internal or external
// (R12) Coding: unsigned or twos complement input
// (R13) Falling latch only with retime stage
// (R14) Retime stage adds one cycle latency
// (R15) Clock input single-ended or differential
// (R16) Calibration clock enable gates calibration clock
// (R17) Divider code halves ratio, 256 to 2
// (R18) Done flag set after calibration completes
// (R19) Start bit begins self-calibration
// (R20) Store writes value into coefficient memory
// (R21) Fetch reads coefficient into value register
// (R22) Restore returns coefficients to defaults
// (R23) Six-bit coefficient address, resets zero
// (R24) Six-bit coefficient value, resets ones
// (R25) Source field: 00, 01 self, 11 user
// (R26) Revision field read-only fixed value
module dac_serial_config_registers #(
  parameter int SAMPLE_WIDTH = 14
) (
  // Clock, reset and enable
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Byte access from the serial port controller
  input wire dac_cfg_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // Sample path
  input wire logic [SAMPLE_WIDTH-1:0] sample_in,
  output logic [SAMPLE_WIDTH-1:0] sample_code,
  // Calibration engine
  input wire logic [5:0] cal_measure,
  output logic cal_clock_pulse,
  // Configuration to the serial controller and analog
  output dac_cfg_pkg::serial_ctl_t serial_config,
  output logic analog_enable,
  output logic output_current_enable,
  output logic master_clock_enable,
  output logic reference_external,
  output logic clock_input_differential,
  output logic latch_on_falling,
  output logic cal_scale_half
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (SAMPLE_WIDTH < 8 || SAMPLE_WIDTH > 14) begin : g_bad_width
    $error("SAMPLE_WIDTH must lie in 8..14");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    dac_cfg_pkg::serial_ctl_t ctl;        // Serial port control register
    dac_cfg_pkg::data_cfg_t dcfg;         // Data path configuration
    logic [2:0] div;                      // Calibration clock divider code
    logic [1:0] src;                      // Calibration source state
    logic done;                           // Calibration complete flag
    dac_cfg_pkg::cal_state_t cal;         // Calibration sequencer
    logic [5:0] step;                     // Coefficient being calibrated
    logic [7:0] divcnt;                   // Divider counter
    logic cal_pulse;                      // Divided calibration clock tick
    logic [5:0] caddr;                    // Coefficient address
    logic [5:0] cval;                     // Coefficient value
    logic trim;                           // Calibration converter scale
    logic [dac_cfg_pkg::COEF_DEPTH-1:0][5:0] mem; // Coefficient storage
    logic [7:0] rdata;                    // Read data
    logic [SAMPLE_WIDTH-1:0] stage1;      // Input latch
    logic [SAMPLE_WIDTH-1:0] stage2;      // Optional retime stage
    logic [SAMPLE_WIDTH-1:0] sout;        // Sample output
    logic cur_en;                         // Output current enable
    logic ana_en;                         // Analog/digital enable
    logic mclk_en;                        // Master clock enable
    logic falling;                        // Effective latch edge
  } state_t;

  state_t s_q;
  state_t s_d;

  // Values computed per cycle
  logic run_clk;
  logic [8:0] period;
  logic [7:0] terminal;
  logic [SAMPLE_WIDTH-1:0] coded;
  logic [7:0] rd_val;

  // ----------------------------------------
  // Reset value of the whole state
  // ----------------------------------------
  function automatic state_t reset_state();
    state_t r;
    r = '0;
    r.ctl = dac_cfg_pkg::SERIAL_CTL_RESET;
    r.dcfg = dac_cfg_pkg::DATA_PATH_RESET;
    r.div = dac_cfg_pkg::DIVIDER_RESET;
    r.src = dac_cfg_pkg::SRC_COEFFICIENT_RESTORE_DEFAULT;
    r.cal = dac_cfg_pkg::CAL_IDLE;
    r.caddr = dac_cfg_pkg::COEF_ADDR_RESET;
    r.cval = dac_cfg_pkg::COEF_VALUE_RESET;
    for (int i = 0; i < dac_cfg_pkg::COEF_DEPTH; i++) begin
      r.mem[i] = dac_cfg_pkg::COEF_DEFAULT;
    end
    r.cur_en = 1'b1;
    r.ana_en = 1'b1;
    r.mclk_en = 1'b1;
    return r;
  endfunction

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    // Internal clock stops under power-down or master clock gate
    run_clk = !s_q.ctl.full_power_down && !s_q.ctl.master_clock_gate; // [R8] [R10]
    // Divider period halves per code step: 256 >> code
    period = dac_cfg_pkg::DIV_BASE_PERIOD >> s_q.div; // [R17]
    terminal = 8'(period - 9'h001);
    // Twos complement flips the sign bit to give offset binary
    coded = sample_in;
    if (s_q.dcfg.sample_coding_select) begin
      coded[SAMPLE_WIDTH-1] = ~sample_in[SAMPLE_WIDTH-1]; // [R12]
    end

    // Read mux over current register contents
    case (reg_req.addr)
      dac_cfg_pkg::ADDR_SERIAL_CTL: rd_val = s_q.ctl;
      dac_cfg_pkg::ADDR_DATA_PATH: rd_val = {s_q.dcfg[7], 2'h0, s_q.dcfg[4:2], 1'b0, s_q.dcfg[0]};
      dac_cfg_pkg::ADDR_REVISION: rd_val = {4'h0, dac_cfg_pkg::REVISION_CODE}; // [R26]
      dac_cfg_pkg::ADDR_CAL_STATE: rd_val = {2'h0, s_q.src, 1'b0, s_q.div}; // [R25]
      dac_cfg_pkg::ADDR_CAL_CMD: begin
        // Command bits read zero; start reads one while running
        rd_val = 8'h00;
        rd_val[dac_cfg_pkg::CAL_DONE_BIT] = s_q.done; // [R18]
        rd_val[dac_cfg_pkg::CAL_START_BIT] = (s_q.cal == dac_cfg_pkg::CAL_RUN);
      end
      dac_cfg_pkg::ADDR_COEF_ADDR: rd_val = {2'h0, s_q.caddr};
      dac_cfg_pkg::ADDR_COEF_VALUE: rd_val = {2'h0, s_q.cval};
      dac_cfg_pkg::ADDR_TRIM: rd_val = {3'h0, s_q.trim, 4'h0};
      default: rd_val = 8'h00; // Unmapped addresses read zero
    endcase
    if (reg_req.rd) begin
      s_d.rdata = rd_val;
    end

    // Calibration clock divider, gated by its enable
    s_d.cal_pulse = 1'b0;
    if (s_q.dcfg.calibration_clock_enable && run_clk) begin // [R16]
      if (s_q.divcnt >= terminal) begin
        s_d.divcnt = 8'h00;
        s_d.cal_pulse = 1'b1; // [R17]
      end else begin
        s_d.divcnt = s_q.divcnt + 8'h01;
      end
    end else begin
      s_d.divcnt = 8'h00;
    end

    // Calibration sequencer: one coefficient per calibration tick
    case (s_q.cal)
      dac_cfg_pkg::CAL_IDLE: begin
      end
      dac_cfg_pkg::CAL_RUN: begin
        if (s_q.cal_pulse) begin
          s_d.mem[s_q.step] = cal_measure;
          s_d.step = s_q.step + 6'h01;
          if (s_q.step == 6'(dac_cfg_pkg::COEF_DEPTH - 1)) begin
            s_d.done = 1'b1; // [R18]
            s_d.src = dac_cfg_pkg::SRC_SELF; // [R25]
            s_d.cal = dac_cfg_pkg::CAL_IDLE;
          end
        end
      end
      default: s_d.cal = dac_cfg_pkg::CAL_IDLE;
    endcase

    // Register writes take effect on the strobe edge
    if (reg_req.wr) begin
      case (reg_req.addr)
        dac_cfg_pkg::ADDR_SERIAL_CTL: begin
          // Port format changes on the strobe edge, once the whole byte is in
          s_d.ctl = reg_req.wdata; // [R1] [R5] [R6] [R7]
        end
        dac_cfg_pkg::ADDR_DATA_PATH: begin
          s_d.dcfg = reg_req.wdata & 8'h9D;
        end
        dac_cfg_pkg::ADDR_CAL_STATE: begin
          s_d.div = reg_req.wdata[2:0]; // [R17]
        end
        dac_cfg_pkg::ADDR_CAL_CMD: begin
          if (reg_req.wdata[dac_cfg_pkg::RESTORE_BIT]) begin
            // Restore has priority over store and fetch
            for (int i = 0; i < dac_cfg_pkg::COEF_DEPTH; i++) begin
              s_d.mem[i] = dac_cfg_pkg::COEF_DEFAULT; // [R22]
            end
            s_d.src = dac_cfg_pkg::SRC_COEFFICIENT_RESTORE_DEFAULT; // [R25]
            s_d.cal = dac_cfg_pkg::CAL_IDLE;
          end else if (reg_req.wdata[dac_cfg_pkg::STORE_BIT]) begin
            s_d.mem[s_q.caddr] = s_q.cval; // [R20] [R23]
            s_d.src = dac_cfg_pkg::SRC_USER; // [R25]
          end else if (reg_req.wdata[dac_cfg_pkg::FETCH_BIT]) begin
            s_d.cval = s_q.mem[s_q.caddr]; // [R21] [R23]
          end
          if (reg_req.wdata[dac_cfg_pkg::CAL_START_BIT]
              && !reg_req.wdata[dac_cfg_pkg::RESTORE_BIT]) begin
            // A new run clears the old completion; a run ending this cycle still sets it
            s_d.cal = dac_cfg_pkg::CAL_RUN; // [R19]
            s_d.step = 6'h00;
            s_d.done = s_d.done && !s_q.done; // [R18]
          end
        end
        dac_cfg_pkg::ADDR_COEF_ADDR: s_d.caddr = reg_req.wdata[5:0]; // [R23]
        dac_cfg_pkg::ADDR_COEF_VALUE: s_d.cval = reg_req.wdata[5:0]; // [R24]
        dac_cfg_pkg::ADDR_TRIM: s_d.trim = reg_req.wdata[dac_cfg_pkg::TRIM_SCALE_BIT];
        default: begin
        end
      endcase
    end

    // Sample path: latch, optional retime stage, output
    if (run_clk) begin
      s_d.stage1 = coded;
      s_d.stage2 = s_q.stage1;
      // Retime stage costs exactly one cycle of latency
      s_d.sout = s_q.dcfg.input_retime_stage_enable ? s_q.stage2 : s_q.stage1; // [R14]
    end

    // Static control outputs follow the registers
    s_d.ana_en = !s_d.ctl.full_power_down; // [R8]
    s_d.cur_en = !s_d.ctl.sleep && !s_d.ctl.full_power_down; // [R9]
    s_d.mclk_en = !s_d.ctl.master_clock_gate; // [R10]
    // Falling edge only honoured with the retime stage on
    s_d.falling = s_d.dcfg.sample_latch_edge_select && s_d.dcfg.input_retime_stage_enable; // [R13]

    // Pending soft reset: one cycle later all but control, the enables it drives and read data go to default.
    // The write that set it wins that cycle; the reset completes next.
    if (s_q.ctl.soft_reset_request) begin
      s_d = reset_state(); // [R2]
      s_d.ctl = s_q.ctl;
      s_d.ctl.soft_reset_request = 1'b0; // [R3]
      s_d.ana_en = !s_q.ctl.full_power_down;
      s_d.cur_en = !s_q.ctl.sleep && !s_q.ctl.full_power_down;
      s_d.mclk_en = !s_q.ctl.master_clock_gate;
      s_d.rdata = s_q.rdata;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_q <= reset_state();
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs, straight from state flops
  // ----------------------------------------
  assign reg_rdata = s_q.rdata;
  assign sample_code = s_q.sout;
  assign cal_clock_pulse = s_q.cal_pulse;
  assign serial_config = s_q.ctl; // [R5] [R6] [R7]
  assign analog_enable = s_q.ana_en;
  assign output_current_enable = s_q.cur_en;
  assign master_clock_enable = s_q.mclk_en;
  assign reference_external = s_q.ctl.reference_source_select; // [R11]
  assign clock_input_differential = s_q.dcfg.clock_input_type_select; // [R15]
  assign latch_on_falling = s_q.falling;
  assign cal_scale_half = s_q.trim;

endmodule

//--- bench/dac_cfg_properties.sv
`timescale 1ns/1ps
module dac_cfg_properties (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Register access
  input wire dac_cfg_pkg::reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  // Control outputs
  input wire dac_cfg_pkg::serial_ctl_t serial_config,
  input wire logic cal_clock_pulse,
  input wire logic analog_enable,
  input wire logic output_current_enable,
  input wire logic master_clock_enable,
  input wire logic reference_external
);
  // ----------------------------------------
  // Shared timing
  // ----------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // Write to the control register this cycle
  logic ctl_wr;
  assign ctl_wr = clk_en && reg_req.wr && reg_req.addr == dac_cfg_pkg::ADDR_SERIAL_CTL;
  // Gate or power-down set now; the tick check also wants it a cycle back, so a tick already launched is excused
  logic held_off;
  assign held_off = serial_config.master_clock_gate || serial_config.full_power_down;
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  a_ctl_write_apply: assert property (ctl_wr |=> serial_config == $past(reg_req.wdata))
    else $error("control byte not applied");
  a_soft_reset_clear: assert property (serial_config.soft_reset_request && clk_en |=>
    !serial_config.soft_reset_request) else $error("soft reset bit stuck");
  a_soft_reset_keep: assert property (serial_config.soft_reset_request && clk_en |=>
    serial_config == ($past(serial_config) & 8'hDF)) else $error("control byte lost");
  // Stable config guards against a one-cycle output lag
  a_power_down_analog: assert property ($stable(serial_config) |->
    analog_enable == !serial_config.full_power_down) else $error("analog enable wrong");
  a_sleep_current_off: assert property ($stable(serial_config) |-> output_current_enable ==
    !(serial_config.sleep || serial_config.full_power_down)) else $error("current enable wrong");
  a_clock_gate_off: assert property ($stable(serial_config) |->
    master_clock_enable == !serial_config.master_clock_gate) else $error("clock enable wrong");
  a_ref_select_out: assert property ($stable(serial_config) |->
    reference_external == serial_config.reference_source_select) else $error("reference wrong");
  a_gated_no_tick: assert property (held_off && $past(held_off) |-> !cal_clock_pulse)
    else $error("calibration tick while gated");
  a_revision_read: assert property (clk_en && reg_req.rd && !serial_config.soft_reset_request
    && reg_req.addr == dac_cfg_pkg::ADDR_REVISION |=> reg_rdata == {4'h0, dac_cfg_pkg::REVISION_CODE})
    else $error("revision wrong");
  // Main scenarios
  cover property (ctl_wr && reg_req.wdata[5]);
  cover property (cal_clock_pulse);
  cover property (reg_req.rd && reg_req.addr == dac_cfg_pkg::ADDR_REVISION);
endmodule

bind dac_serial_config_registers dac_cfg_properties u_props (.core_clk(core_clk), .reset_n(reset_n),
  .clk_en(clk_en), .reg_req(reg_req), .reg_rdata(reg_rdata), .serial_config(serial_config),
  .cal_clock_pulse(cal_clock_pulse), .analog_enable(analog_enable),
  .output_current_enable(output_current_enable), .master_clock_enable(master_clock_enable),
  .reference_external(reference_external));

//--- bench/byte_host.sv
`timescale 1ns/1ps
// Serial controller stand-in: hands over whole bytes, one per transfer
module byte_host (
  // Clock
  input wire logic core_clk,
  // Byte access
  output dac_cfg_pkg::reg_req_t reg_req,
  input wire logic [7:0] reg_rdata
);
  initial reg_req = '0;
  // Single-byte write; strobe drops before the next one, which spaces writes two cycles apart
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk) reg_req <= '{1'b1, 1'b0, {5'h00, a}, d};
    @(posedge core_clk) reg_req.wr <= 1'b0;
  endtask
  // Single-byte read; the byte is taken one edge after the strobe is seen
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk) reg_req <= '{1'b0, 1'b1, {5'h00, a}, 8'h00};
    @(posedge core_clk) reg_req.rd <= 1'b0;
    @(posedge core_clk) d = reg_rdata;
  endtask
endmodule

//--- bench/dac_serial_config_registers_tb_top.sv
`timescale 1ns/1ps
module dac_serial_config_registers_tb_top;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic core_clk, reset_n, clk_en;
  dac_cfg_pkg::reg_req_t reg_req;
  logic [7:0] reg_rdata, d;
  logic [13:0] sample_in, sample_code;
  logic [5:0] cal_measure;
  logic cal_clock_pulse, ae, ce, me, re, di, lf, sh;
  dac_cfg_pkg::serial_ctl_t serial_config;
  int n_fail = 0, n_tests = 0, cyc = 0, n;
  // Row: address, byte written, readback, reset value, packed outputs
  typedef struct {logic [7:0] a, w, r, z; logic [6:0] o;} row_t;
  row_t rows [14] = '{'{8'h00, 8'h84, 8'h84, 8'h00, 7'h50}, '{8'h00, 8'h82, 8'h82, 8'h00, 7'h60},
    '{8'h00, 8'h89, 8'h89, 8'h00, 7'h18}, '{8'h00, 8'h50, 8'h50, 8'h00, 7'h70},
    '{8'h00, 8'h80, 8'h80, 8'h00, 7'h70}, '{8'h02, 8'hFF, 8'h9D, 8'h00, 7'h76},
    '{8'h02, 8'h10, 8'h10, 8'h00, 7'h70}, '{8'h14, 8'hFF, 8'h10, 8'h00, 7'h71},
    '{8'h0D, 8'hFF, 8'h01, 8'h01, 7'h71}, '{8'h0E, 8'hFF, 8'h07, 8'h00, 7'h71},
    '{8'h10, 8'hFF, 8'h3F, 8'h00, 7'h71}, '{8'h11, 8'hFF, 8'h3F, 8'h3F, 7'h71},
    '{8'h01, 8'hFF, 8'h00, 8'h00, 7'h71}, '{8'h0F, 8'h00, 8'h00, 8'h00, 7'h71}};
  // ----------------------------------------
  // Design, host and clock
  // ----------------------------------------
  dac_serial_config_registers dut (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .sample_in(sample_in), .sample_code(sample_code),
    .cal_measure(cal_measure), .cal_clock_pulse(cal_clock_pulse), .serial_config(serial_config),
    .analog_enable(ae), .output_current_enable(ce), .master_clock_enable(me),
    .reference_external(re), .clock_input_differential(di), .latch_on_falling(lf), .cal_scale_half(sh));
  byte_host host (.core_clk(core_clk), .reg_req(reg_req), .reg_rdata(reg_rdata));
  always #20 core_clk = ~core_clk;
  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic stop_test();
    if (n_fail == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Cycles until the next calibration tick, 600 if none comes; looks just after the edge
  task automatic wait_tick(output int c);
    c = 0;
    do begin
      @(posedge core_clk);
      #1;
      c++;
    end while (cal_clock_pulse !== 1'b1 && c < 600);
  endtask
  // Reset values of every register except the control byte
  task automatic reset_reads();
    foreach (rows[i]) if (rows[i].a != 8'h00) begin
      host.rd(rows[i].a, d);
      chk("reset value", d, rows[i].z);
    end
  endtask
  // Latency of the sample path: new value not yet out one edge early, new value on time
  task automatic samp(input logic [7:0] cfg, input logic [13:0] v, input logic [13:0] e, input int k);
    host.wr(8'h02, cfg);
    repeat (5) @(posedge core_clk);
    sample_in <= v;
    repeat (k - 1) @(posedge core_clk);
    #1 chk("sample early", sample_code == e, 1'b0);
    @(posedge core_clk);
    #1 chk("sample code", sample_code, e);
    @(posedge core_clk) sample_in <= '0;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    core_clk = 0;
    reset_n = 0;
    clk_en = 1;
    sample_in = '0;
    cal_measure = 6'h15;
    repeat (20) @(posedge core_clk);
    reset_n <= 1;
    host.rd(8'h00, d);
    chk("control reset", d, dac_cfg_pkg::SERIAL_CTL_RESET);
    reset_reads();
    // Ordinary cases: write, read back, look at the control outputs
    foreach (rows[i]) begin
      host.wr(rows[i].a, rows[i].w);
      host.rd(rows[i].a, d);
      chk("readback", d, rows[i].r);
      chk("outputs", {ae, ce, me, re, di, lf, sh}, rows[i].o);
    end
    samp(8'h00, 14'h1234, 14'h1234, 2);
    samp(8'h88, 14'h0234, 14'h2234, 3);
    // Self-calibration, measuring the tick period at every divider code on the way
    host.wr(8'h02, 8'h01);
    host.wr(8'h0F, 8'h40);
    for (int i = 0; i < 8; i++) begin
      host.wr(8'h0E, 8'(i));
      wait_tick(n);
      wait_tick(n);
      wait_tick(n);
      chk("tick period", 16'(n), 16'(256 >> i));
    end
    host.wr(8'h0E, 8'h07);
    repeat (300) @(posedge core_clk);
    host.rd(8'h0F, d);
    chk("cal done", d[7], 1'b1);
    host.rd(8'h0E, d);
    chk("cal source", d, 8'h17);
    host.wr(8'h10, 8'h3F);
    host.wr(8'h0F, 8'h04);
    host.rd(8'h11, d);
    chk("cal entry", d, 8'h15);
    host.wr(8'h02, 8'h00);
    wait_tick(n);
    chk("tick gated", 16'(n), 16'd600);
    // User store, fetch back, then restore to defaults
    host.wr(8'h10, 8'h05);
    host.wr(8'h11, 8'h2A);
    host.wr(8'h0F, 8'h08);
    host.rd(8'h0E, d);
    chk("user source", d, 8'h37);
    host.wr(8'h11, 8'h00);
    host.wr(8'h0F, 8'h04);
    host.rd(8'h11, d);
    chk("fetch stored", d, 8'h2A);
    host.wr(8'h0F, 8'h01);
    host.wr(8'h0F, 8'h04);
    host.rd(8'h11, d);
    chk("fetch default", d, {2'h0, dac_cfg_pkg::COEF_DEFAULT});
    host.rd(8'h0E, d);
    chk("coefficient_restore_default source", d, 8'h07);
    // Soft reset keeps the control byte and clears its own bit
    host.wr(8'h00, 8'hA9);
    repeat (2) @(posedge core_clk);
    #1 chk("control kept", serial_config, 8'h89);
    chk("power down", {ae, ce, re}, 3'h1);
    reset_reads();
    // Enable low freezes all state, so a strobe in that time is lost
    clk_en <= 1'b0;
    host.wr(8'h11, 8'h00);
    @(posedge core_clk) clk_en <= 1'b1;
    host.rd(8'h11, d);
    chk("frozen write", d, 8'h3F);
    stop_test();
  end
endmodule
